/* ebm_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ebm_mem_model import ebm_pkg::*; (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [WADDR_W-1:0] word_addr,
    input wire logic addr_strobe_n,
    input wire logic last_transfer_flag_n,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic data_oe,
    input wire logic [3:0] delay,
    output logic [DATA_W-1:0] data_in,
    output logic ready_n
);
    logic [DATA_W-1:0] mem [256];
    logic [DATA_W-1:0] junk;
    logic act;
    logic fl_q;
    logic [3:0] cnt;
    // Access window, ready delay and write capture
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            act <= 1'b0;
            cnt <= 4'h0;
            fl_q <= 1'b1;
            junk <= 32'hA5A5_5A5A;
        end else begin
            fl_q <= last_transfer_flag_n;
            junk <= ~junk;
            if (cnt != 4'hF) cnt <= cnt + 4'h1;
            if (!addr_strobe_n) begin
                act <= 1'b1;
                cnt <= 4'h0;
            end else if (last_transfer_flag_n && !fl_q) begin
                act <= 1'b0;
            end
            if (data_oe) mem[word_addr[7:0]] <= data_out;
        end
    end
    // Data only inside an access, else a moving pattern
    assign data_in = act ? mem[word_addr[7:0]] : junk;
    // Ready only once data is trustworthy
    assign ready_n = !(act && cnt >= delay);
endmodule
`default_nettype wire

/* ebm_pkg.sv */
package ebm_pkg;
    // Widths of the register port, the bus and the wait fields, and beat and region counts
    localparam int REG_AW = 8;
    localparam int DATA_W = 32;
    localparam int WADDR_W = 30;
    localparam int WAIT_W = 4;
    localparam int NBEAT = 4;
    localparam int NREGION = 4;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ADDR = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_WDATA = 8'h10;
    localparam logic [7:0] OFS_RDATA = 8'h20;
    localparam logic [7:0] OFS_REGION = 8'h30;

    // Control register fields
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_WR_BIT = 1;
    localparam int CTRL_CNT_LSB = 2;
    localparam int CTRL_BE_LSB = 4;

    // Region configuration fields
    localparam int CFG_WIDTH_LSB = 0;
    localparam int CFG_PIPE_BIT = 2;
    localparam int CFG_RDYEN_BIT = 3;
    localparam int CFG_RFIRST_LSB = 4;
    localparam int CFG_RBURST_LSB = 8;
    localparam int CFG_WFIRST_LSB = 12;
    localparam int CFG_WBURST_LSB = 16;
    localparam int CFG_POST_LSB = 20;
    localparam logic [23:0] CFG_RST = 24'h000002;

    // Ready input synchroniser depth
    localparam int RDY_SYNC = 3;

    typedef enum logic [1:0] {
        W8 = 2'b00,
        W16 = 2'b01,
        W32 = 2'b10
    } bus_width_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_DATA = 2'b10,
        ST_POST = 2'b11
    } bus_state_e;
endpackage

/* ebm_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module ebm_properties import ebm_pkg::*; (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [WADDR_W-1:0] word_addr,
    input wire logic dir_read,
    input wire logic addr_strobe_n,
    input wire logic last_transfer_flag_n,
    input wire logic data_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // Strobe framing and direction timing
    a_strobe_one_clock: assert property (!addr_strobe_n |=> addr_strobe_n)
        else $error("strobe held too long");
    a_dir_with_strobe: assert property ($changed(dir_read) |-> !addr_strobe_n)
        else $error("direction moved outside strobe");
    a_dir_held_final: assert property (!last_transfer_flag_n |-> $stable(dir_read))
        else $error("direction moved in final beat");
    a_dir_after_strobe: assert property (!addr_strobe_n |=> $stable(dir_read))
        else $error("direction moved after strobe");
    a_write_drives_low: assert property (data_oe |-> !dir_read)
        else $error("data driven on a read");
    // Last-transfer flag placement and upper address hold
    a_flag_follows_strobe: assert property (!addr_strobe_n |-> ##[1:60] !last_transfer_flag_n)
        else $error("no last transfer");
    a_flag_not_strobe: assert property (!addr_strobe_n |-> last_transfer_flag_n)
        else $error("flag in address cycle");
    a_flag_releases: assert property ($fell(last_transfer_flag_n) |-> ##[1:40] last_transfer_flag_n)
        else $error("flag stuck");
    a_addr_upper_fixed: assert property (!addr_strobe_n |=> $stable(word_addr[WADDR_W-1:2]))
        else $error("upper address moved");
    // Main scenarios
    c_read: cover property (!addr_strobe_n && dir_read);
    c_write: cover property (!addr_strobe_n && !dir_read);
    c_stall: cover property (!last_transfer_flag_n [*3]);
endmodule
`default_nettype wire

/* external_burst_bus_master.sv */
// Function
// [R1] Drive 30-bit word address, word aligned
// [R2] Step low word-address bits each burst beat
// [R3] Data on lanes matching region width
// [R4] 32-bit: four byte-lane selects per byte
// [R5] 16-bit: high enable, A1, low enable
// [R6] 8-bit: selects carry A1 and A0
// [R7] Direction high for reads, low writes
// [R8] Direction changes only with address strobe
// [R9] Direction held valid across whole access
// [R10] Address strobe for first clock only
// [R11] Partner asserts ready only when data done
// [R12] Sample ready after programmed waits expire
// [R13] Deasserted ready keeps adding wait states
// [R14] Post-access idle never extended by ready
// [R15] Last-transfer flag on final beat, zero count
// [R16] Outputs synchronous, inputs sampled on clock
// [R17] Per-access region configuration selects behaviour
`timescale 1ns/100ps
`default_nettype none
module external_burst_bus_master import ebm_pkg::*; (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [REG_AW-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    output logic [WADDR_W-1:0] word_addr,
    output logic lane_sel_3_n,
    output logic lane_sel_2_n,
    output logic lane_sel_1_n,
    output logic lane_sel_0_n,
    output logic dir_read,
    output logic addr_strobe_n,
    output logic last_transfer_flag_n,
    input wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe,
    input wire logic ready_n
);
    bus_state_e state_r, state_nxt;
    logic [23:0] region_r [NREGION];
    logic [DATA_W-1:0] wdata_r [NBEAT];
    logic [DATA_W-1:0] rdata_r [NBEAT];
    logic [DATA_W-1:0] base_r;
    logic [1:0] cnt_r;
    logic [3:0] be_r;
    logic wr_r;
    logic [23:0] cfg_r;
    logic [1:0] idx_r;
    logic [DATA_W-1:0] rd_mux;
    logic [DATA_W-1:0] reg_rdata_r;
    logic [RDY_SYNC-1:0] rdy_sync_r;
    logic ready_q_r;
    logic [WADDR_W-1:0] word_addr_r;
    logic [3:0] lane_r;
    logic dir_r;
    logic [DATA_W-1:0] dout_r;

    wait_if w ();

    wait_counter u_wait (
        .mclk(mclk),
        .nrst(nrst),
        .w(w)
    );

    // Register port decode
    wire busy = (state_r != ST_IDLE);
    wire sel_ctrl = (reg_addr == OFS_CTRL);
    wire sel_addr = (reg_addr == OFS_ADDR);
    wire sel_stat = (reg_addr == OFS_STATUS);
    wire sel_wdat = (reg_addr[7:4] == OFS_WDATA[7:4]) && (reg_addr[1:0] == 2'b00);
    wire sel_rdat = (reg_addr[7:4] == OFS_RDATA[7:4]) && (reg_addr[1:0] == 2'b00);
    wire sel_reg = (reg_addr[7:4] == OFS_REGION[7:4]) && (reg_addr[1:0] == 2'b00);
    wire [1:0] sub_idx = reg_addr[3:2];
    wire go = reg_wr && sel_ctrl && reg_wdata[CTRL_GO_BIT] && !busy;

    // Configuration of the region hit by the request address
    wire [23:0] cfg_new = region_r[base_r[31:30]];

    // Fields of the latched region configuration, and the width of the new one
    wire [1:0] width = cfg_r[CFG_WIDTH_LSB +: 2];
    wire pipe_en = cfg_r[CFG_PIPE_BIT];
    wire rdy_en = cfg_r[CFG_RDYEN_BIT];
    wire [WAIT_W-1:0] n_rfirst = cfg_r[CFG_RFIRST_LSB +: WAIT_W];
    wire [WAIT_W-1:0] n_rburst = cfg_r[CFG_RBURST_LSB +: WAIT_W];
    wire [WAIT_W-1:0] n_wfirst = cfg_r[CFG_WFIRST_LSB +: WAIT_W];
    wire [WAIT_W-1:0] n_wburst = cfg_r[CFG_WBURST_LSB +: WAIT_W];
    wire [WAIT_W-1:0] n_post = cfg_r[CFG_POST_LSB +: WAIT_W];
    wire [1:0] width_new = cfg_new[CFG_WIDTH_LSB +: 2];

    // Beat bookkeeping
    wire last_beat = (idx_r == cnt_r);
    wire in_data = (state_r == ST_DATA);
    wire beat_done = in_data && w.done;
    wire advance = beat_done && !last_beat;
    wire start = (state_r == ST_ADDR);

    // Address and lane values of the next beat
    wire [1:0] idx_nxt = start ? 2'b00 : idx_r + 2'd1;
    wire [1:0] w_nxt = start ? width_new : width;
    wire [3:0] step = (w_nxt == W32) ? {idx_nxt, 2'b00} :
                      (w_nxt == W16) ? {1'b0, idx_nxt, 1'b0} :
                      {2'b00, idx_nxt};
    // Narrow regions keep the byte bits so A1 and A0 reach the lane selects
    wire [3:0] low_base = (w_nxt == W32) ? {base_r[3:2], 2'b00} : base_r[3:0];
    // Low bits wrap, so a burst never carries into the upper address
    wire [3:0] low_addr = low_base + step; // [R2]
    wire [DATA_W-1:0] baddr = {base_r[31:4], low_addr}; // [R1] [R2]
    wire [3:0] be_hi = {be_r[1], 1'b1, baddr[1], be_r[0]};
    wire [3:0] lane_nxt = (w_nxt == W32) ? be_r : // [R4]
                          (w_nxt == W16) ? be_hi : // [R5]
                          {2'b11, baddr[1:0]}; // [R6]
    wire [DATA_W-1:0] wsrc = wdata_r[idx_nxt];
    wire [DATA_W-1:0] wlanes = (w_nxt == W32) ? wsrc :
                               (w_nxt == W16) ? {16'h0, wsrc[15:0]} :
                               {24'h0, wsrc[7:0]}; // [R3]
    wire [DATA_W-1:0] rlanes = (width == W32) ? data_in :
                               (width == W16) ? {16'h0, data_in[15:0]} :
                               {24'h0, data_in[7:0]}; // [R3]

    // Status word
    wire [DATA_W-1:0] status = {24'h0, pipe_en, rdy_en, idx_r, 1'b0,
                                state_r, busy};

    // Readback selection
    assign rd_mux = sel_ctrl ? {24'h0, be_r, cnt_r, wr_r, 1'b0} :
                    sel_addr ? base_r :
                    sel_stat ? status :
                    sel_wdat ? wdata_r[sub_idx] :
                    sel_rdat ? rdata_r[sub_idx] :
                    sel_reg ? {8'h0, region_r[sub_idx]} :
                    32'h0;

    // Wait counter control per phase
    always_comb begin
        w.load = 1'b0;
        w.load_val = '0;
        w.use_ready = rdy_en && in_data; // [R12] [R14]
        w.ready_s = !ready_q_r; // [R11]
        if (start) begin
            w.load = 1'b1;
            w.load_val = wr_r ? cfg_new[CFG_WFIRST_LSB +: WAIT_W] :
                                cfg_new[CFG_RFIRST_LSB +: WAIT_W];
        end else if (advance) begin
            w.load = 1'b1;
            w.load_val = wr_r ? n_wburst : n_rburst; // [R13]
        end else if (beat_done) begin
            w.load = 1'b1;
            w.load_val = n_post; // [R14]
        end
    end

    // Next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (go) begin
                    state_nxt = ST_ADDR;
                end
            end
            ST_ADDR: begin
                state_nxt = ST_DATA;
            end
            ST_DATA: begin
                if (beat_done && last_beat) begin
                    state_nxt = (n_post == '0) ? ST_IDLE : ST_POST;
                end
            end
            ST_POST: begin
                if (w.done) begin
                    state_nxt = ST_IDLE; // [R14]
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt; // [R16]
        end
    end

    // Ready pin synchroniser, change taken when stages agree
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdy_sync_r <= '1;
            ready_q_r <= 1'b1;
        end else begin
            rdy_sync_r <= {rdy_sync_r[RDY_SYNC-2:0], ready_n}; // [R16]
            if (rdy_sync_r[1] == rdy_sync_r[2]) begin
                ready_q_r <= rdy_sync_r[2];
            end
        end
    end

    // Request registers, writable only while idle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            base_r <= '0;
            cnt_r <= '0;
            be_r <= 4'hF;
            wr_r <= 1'b0;
        end else if (reg_wr && !busy) begin
            if (sel_addr) begin
                base_r <= reg_wdata;
            end
            if (sel_ctrl) begin
                wr_r <= reg_wdata[CTRL_WR_BIT];
                cnt_r <= reg_wdata[CTRL_CNT_LSB +: 2];
                be_r <= reg_wdata[CTRL_BE_LSB +: 4];
            end
        end
    end

    // Per-entry storage for regions, write and read data
    genvar gi;
    generate
        for (gi = 0; gi < NBEAT; gi++) begin : g_entry
            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    region_r[gi] <= CFG_RST;
                    wdata_r[gi] <= '0;
                    rdata_r[gi] <= '0;
                end else begin
                    if (reg_wr && !busy && sel_reg && sub_idx == gi) begin
                        region_r[gi] <= reg_wdata[23:0];
                    end
                    if (reg_wr && !busy && sel_wdat && sub_idx == gi) begin
                        wdata_r[gi] <= reg_wdata;
                    end
                    if (beat_done && !wr_r && idx_r == gi) begin
                        rdata_r[gi] <= rlanes;
                    end
                end
            end
        end
    endgenerate

    // Region latch and beat index
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cfg_r <= CFG_RST;
            idx_r <= '0;
        end else if (start) begin
            cfg_r <= cfg_new; // [R17]
            idx_r <= '0;
        end else if (advance) begin
            idx_r <= idx_nxt; // [R2]
        end
    end

    // Registered pin values, updated at strobe and each new beat
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            word_addr_r <= '0;
            lane_r <= 4'hF;
            dout_r <= '0;
        end else if (start || advance) begin
            word_addr_r <= baddr[31:2]; // [R1] [R2]
            lane_r <= lane_nxt; // [R4] [R5] [R6]
            dout_r <= wlanes; // [R3]
        end
    end

    // Direction changes only when a new access is strobed
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            dir_r <= 1'b0;
        end else if (go) begin
            dir_r <= !reg_wdata[CTRL_WR_BIT]; // [R7] [R8] [R9]
        end
    end

    // Registered read data, valid the cycle after reg_rd, else zero
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata_r <= '0;
        end else if (reg_rd) begin
            reg_rdata_r <= rd_mux;
        end else begin
            reg_rdata_r <= '0;
        end
    end

    // Pin outputs
    assign reg_rdata = reg_rdata_r;
    assign addr_strobe_n = !start; // [R10]
    assign word_addr = start ? baddr[31:2] : word_addr_r; // [R1]
    assign lane_sel_3_n = start ? lane_nxt[3] : lane_r[3];
    assign lane_sel_2_n = start ? lane_nxt[2] : lane_r[2];
    assign lane_sel_1_n = start ? lane_nxt[1] : lane_r[1];
    assign lane_sel_0_n = start ? lane_nxt[0] : lane_r[0];
    assign dir_read = dir_r; // [R8] [R9]
    assign last_transfer_flag_n = !(in_data && last_beat && w.zero); // [R15]
    assign data_out = dout_r;
    assign data_oe = in_data && wr_r; // [R3]
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top import ebm_pkg::*; ;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [REG_AW-1:0] reg_addr = 8'h00;
    logic [DATA_W-1:0] reg_wdata = 32'h0;
    logic [3:0] delay = 4'h0;
    logic [DATA_W-1:0] reg_rdata, data_in, data_out;
    logic [WADDR_W-1:0] word_addr, st_addr, fl_addr;
    logic [3:0] lanes, st_lanes;
    logic dir_read, addr_strobe_n, last_transfer_flag_n, data_oe, ready_n, st_dir;
    logic fl_q = 1'b1;
    logic narrow8 = 1'b0;
    int fail_count = 0;
    int num_checks = 0;
    int seed = 32'h92EE6D04;
    int tlen = 0;
    int alen = 0;
    external_burst_bus_master dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .word_addr(word_addr), .lane_sel_3_n(lanes[3]), .lane_sel_2_n(lanes[2]),
        .lane_sel_1_n(lanes[1]), .lane_sel_0_n(lanes[0]), .dir_read(dir_read),
        .addr_strobe_n(addr_strobe_n), .last_transfer_flag_n(last_transfer_flag_n),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .ready_n(ready_n));
    ebm_mem_model mem (.mclk(mclk), .nrst(nrst), .word_addr(word_addr),
        .addr_strobe_n(addr_strobe_n), .last_transfer_flag_n(last_transfer_flag_n),
        .data_out(data_out), .data_oe(data_oe), .delay(delay), .data_in(data_in),
        .ready_n(ready_n));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // One bus access, polled until idle
    task automatic acc(input logic [31:0] a, input bit w, input int n, input logic [3:0] be);
        logic [31:0] v;
        int k;
        wr(OFS_ADDR, a);
        wr(OFS_CTRL, {24'h0, be, n[1:0], w, 1'b1});
        k = 0;
        v = 32'h1;
        while (v[0] === 1'b1 && k < 200) begin
            rd(OFS_STATUS, v);
            k++;
        end
        chk("busy", 32'h0, {31'h0, v[0]});
        chk("strobe addr", {2'b0, a[31:2]}, {2'b0, st_addr});
        chk("dir", {31'h0, !w}, {31'h0, st_dir});
    endtask
    // Strobe-cycle capture and access length
    always @(posedge mclk) begin
        tlen <= tlen + 1;
        fl_q <= last_transfer_flag_n;
        if (last_transfer_flag_n && !fl_q) alen <= tlen;
        if (!last_transfer_flag_n) fl_addr <= word_addr;
        if (!addr_strobe_n) begin
            st_addr <= word_addr;
            st_lanes <= lanes;
            st_dir <= dir_read;
            tlen <= 1;
        end
        if (data_oe && narrow8) chk("upper lanes", 32'h0, {8'h0, data_out[31:8]});
    end
    initial begin
        forever #4 mclk = ~mclk;
    end
    initial begin
        #200000;
        fail_count++;
        final_report();
    end
    initial begin
        logic [31:0] v, a, d, m;
        logic [31:0] dat [4];
        logic [3:0] ex;
        int i, j;
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        rd(OFS_STATUS, v);
        chk("status", 32'h0, v);
        rd(OFS_REGION, v);
        chk("region0", {8'h0, CFG_RST}, v);
        rd(8'h40, v);
        chk("unmapped", 32'h0, v);
        wr(OFS_REGION + 8'h4, 32'h1);
        wr(OFS_REGION + 8'h8, 32'h0);
        $display("test reset done");
        a = $random(seed) & 32'h3FFF_FFF0;
        for (i = 0; i < 4; i++) begin
            dat[i] = $random(seed);
            wr(OFS_WDATA + 8'(4 * i), dat[i]);
        end
        d = $random(seed);
        acc(a, 1'b1, 3, d[3:0]);
        chk("lanes32", {28'h0, d[3:0]}, {28'h0, st_lanes});
        chk("burst len", 32'd5, alen);
        chk("last beat", {2'b0, a[31:2] + 30'h3}, {2'b0, fl_addr});
        acc(a, 1'b0, 3, 4'h0);
        for (i = 0; i < 4; i++) begin
            rd(OFS_RDATA + 8'(4 * i), v);
            chk("rdata32", dat[i], v);
        end
        $display("test burst done");
        for (j = 1; j <= 2; j++) begin
            a = {j[1:0], 30'($random(seed))};
            d = $random(seed);
            narrow8 = (j == 2);
            wr(OFS_WDATA, d);
            acc(a, 1'b1, 0, d[3:0]);
            ex = (j == 1) ? {d[1], st_lanes[2], a[1], d[0]} : {st_lanes[3:2], a[1:0]};
            chk("lanes narrow", {28'h0, ex}, {28'h0, st_lanes});
            narrow8 = 1'b0;
            acc(a, 1'b0, 0, 4'h0);
            rd(OFS_RDATA, v);
            m = (j == 1) ? 32'h0000_FFFF : 32'h0000_00FF;
            chk("rdata narrow", d & m, v & m);
        end
        $display("test narrow done");
        for (j = 0; j < 2; j++) begin
            wr(OFS_REGION + 8'hC, 32'h0020_0032 | (j << 3));
            rd(OFS_REGION + 8'hC, v);
            chk("region3", 32'h0020_0032 | (j << 3), v);
            delay <= 4'h9;
            acc(32'hC000_0100, 1'b0, 0, 4'h0);
            if (j == 0) chk("wait len", 32'd5, alen);
            else chk("ready stall", 32'd1, {31'h0, alen > 5});
        end
        $display("test ready done");
        final_report();
    end
endmodule
bind external_burst_bus_master ebm_properties u_props (.mclk(mclk), .nrst(nrst),
    .word_addr(word_addr), .dir_read(dir_read), .addr_strobe_n(addr_strobe_n),
    .last_transfer_flag_n(last_transfer_flag_n), .data_oe(data_oe));
`default_nettype wire

/* wait_counter.sv */
`timescale 1ns/100ps
`default_nettype none
module wait_counter import ebm_pkg::*; (
    input wire logic mclk,
    input wire logic nrst,
    wait_if.cnt w
);
    logic [WAIT_W-1:0] cnt_r;

    // Phase ends at zero count, with ready only where enabled
    assign w.zero = (cnt_r == '0);
    assign w.done = w.zero && (!w.use_ready || w.ready_s); // [R12] [R13] [R14]

    // Load on phase start, else count down to zero
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= '0;
        end else if (w.load) begin
            cnt_r <= w.load_val;
        end else if (!w.zero) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end
endmodule
`default_nettype wire

/* wait_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface wait_if;
    import ebm_pkg::*;
    logic load;
    logic [WAIT_W-1:0] load_val;
    logic use_ready;
    logic ready_s;
    logic zero;
    logic done;
    modport ctl (output load, load_val, use_ready, ready_s, input zero, done);
    modport cnt (input load, load_val, use_ready, ready_s, output zero, done);
endinterface
`default_nettype wire
